// ===== bench/general_timers_watchdog_monitor.sv
`timescale 1ns/100ps
module general_timers_watchdog_monitor (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_clock_enable,
    input wire logic [5:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic [3:0] o_timer_irq,
    input wire logic o_watchdog_irq,
    input wire logic o_irq,
    input wire logic o_system_reset
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // a request taken while idle, then a one-cycle answer
    sequence s_request;
        (i_read || i_write) && o_waitrequest && i_clock_enable;
    endsequence
    sequence s_answer;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    a_bus_answer: assert property (s_request |=> s_answer)
        else $error("bus answer not a single cycle");
    a_bus_idle: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
        else $error("answer without a request");
    a_unmapped_zero: assert property (i_read && o_waitrequest && i_clock_enable
        && (i_address inside {[6'h05:6'h0F], [6'h20:6'h3F]}) |=> o_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_merge: assert property (o_irq == (|o_timer_irq || o_watchdog_irq))
        else $error("merged interrupt disagrees");
    a_reset_sticky: assert property (o_system_reset |=> o_system_reset)
        else $error("system reset dropped");
    a_ack_no_reset: assert property (i_write && !o_waitrequest && i_clock_enable
        && i_address == 6'h03 |=> ##1 !$rose(o_system_reset))
        else $error("system reset right after acknowledge");
    a_reset_clean: assert property ($fell(i_reset) |-> o_waitrequest && !o_irq
        && !o_system_reset && o_readdata == 32'h0)
        else $error("outputs not idle after reset");
    a_freeze_state: assert property (!i_clock_enable |=> $stable(o_irq) && $stable(o_system_reset))
        else $error("state moved while frozen");
    a_reset_enabled: assert property ($rose(o_system_reset) |-> $past(i_clock_enable))
        else $error("system reset rose while frozen");
endmodule
bind general_timers_watchdog general_timers_watchdog_monitor general_timers_watchdog_monitor_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(i_clock_enable),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_timer_irq(o_timer_irq),
    .o_watchdog_irq(o_watchdog_irq), .o_irq(o_irq), .o_system_reset(o_system_reset));

// ===== bench/tb_general_timers_watchdog.sv
`timescale 1ns/100ps
module tb_general_timers_watchdog;
    typedef struct packed {logic [5:0] addr; logic wr; logic [31:0] data;} row_s;
    logic i_clock = 1'h0;
    logic i_reset = 1'h1;
    logic i_clock_enable = 1'h1;
    logic [5:0] i_address = 6'h00;
    logic i_read = 1'h0;
    logic i_write = 1'h0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'hF;
    logic [3:0] i_general_pin_event = 4'h0;
    logic [31:0] o_readdata;
    logic [3:0] o_timer_irq;
    logic o_waitrequest, o_watchdog_irq, o_irq, o_system_reset;
    logic [31:0] rd, rd2;
    logic [5:0] watched;
    int num_errors = 0;
    int total_checks = 0;
    int n;
    // read rows compare, write rows only store
    row_s rows [13] = '{'{6'h02, 1'h0, 32'h20}, '{6'h02, 1'h1, 32'hFFFF},
        '{6'h03, 1'h1, 32'h1}, '{6'h03, 1'h0, 32'h0}, '{6'h01, 1'h0, 32'h0},
        '{6'h01, 1'h1, 32'hFFFFFFFF}, '{6'h01, 1'h0, 32'h1F}, '{6'h05, 1'h1, 32'h5A5A5A5A},
        '{6'h05, 1'h0, 32'h0}, '{6'h15, 1'h1, 32'hAB123456}, '{6'h15, 1'h0, 32'h123456},
        '{6'h14, 1'h0, 32'h0}, '{6'h00, 1'h0, 32'h0}};
    assign watched = {o_system_reset, o_watchdog_irq, o_timer_irq};
    always #25 i_clock = ~i_clock;
    general_timers_watchdog #(.WATCHDOG_PERIOD(24'h000020)) general_timers_watchdog_inst (
        .i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(i_clock_enable),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_general_pin_event(i_general_pin_event),
        .o_timer_irq(o_timer_irq), .o_watchdog_irq(o_watchdog_irq), .o_irq(o_irq),
        .o_system_reset(o_system_reset));
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        total_checks++;
        if (seen !== expected) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, expected, seen);
        end
    endtask
    // one Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] addr, input logic [31:0] data);
        int k;
        k = 0;
        @(posedge i_clock);
        i_read <= !wr;
        i_write <= wr;
        i_address <= addr;
        i_writedata <= data;
        do begin
            @(posedge i_clock);
            k++;
        end while (o_waitrequest !== 1'h0 && k < 50);
        rd = o_readdata;
        i_read <= 1'h0;
        i_write <= 1'h0;
        check("bus answer", {31'h0, k < 50}, 32'h1);
    endtask
    // count edges until one output bit is seen high
    task automatic wait_bit(input int idx, input int limit);
        n = 0;
        while (watched[idx] !== 1'h1 && n < limit) begin
            @(posedge i_clock);
            n++;
        end
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #(50 * 20000);
        num_errors++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        repeat (12) @(posedge i_clock);
        i_reset <= 1'h0;
        @(posedge i_clock);
        check("idle outputs", {o_waitrequest, o_irq, o_system_reset, o_timer_irq}, 32'h40);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr) begin
                check($sformatf("register %h", rows[i].addr), rd, rows[i].data);
            end
        end
        // single shot, reload 3, prescale 2
        bus(1'h1, 6'h11, 32'h3);
        bus(1'h1, 6'h10, 32'h5);
        wait_bit(0, 40);
        check("single shot delay", {31'h0, n >= 10 && n <= 18}, 32'h1);
        bus(1'h1, 6'h01, 32'h1E);
        bus(1'h1, 6'h00, 32'h1);
        bus(1'h1, 6'h10, 32'h5);
        repeat (30) @(posedge i_clock);
        check("masked irq", {o_timer_irq, o_irq}, 32'h0);
        bus(1'h0, 6'h00, 32'h0);
        check("masked status", rd, 32'h1);
        bus(1'h1, 6'h01, 32'h1F);
        repeat (2) @(posedge i_clock);
        check("unmasked irq", {o_timer_irq, o_irq}, 32'h3);
        bus(1'h1, 6'h00, 32'h1);
        repeat (30) @(posedge i_clock);
        check("single shot stopped", {o_timer_irq, o_irq}, 32'h0);
        // multi shot keeps reloading
        bus(1'h1, 6'h15, 32'h8);
        bus(1'h1, 6'h14, 32'h11);
        wait_bit(1, 20);
        bus(1'h1, 6'h00, 32'h2);
        @(posedge i_clock);
        check("multi cleared", {o_timer_irq, o_irq}, 32'h0);
        wait_bit(1, 20);
        check("multi second expiry", {31'h0, n >= 3 && n < 20}, 32'h1);
        bus(1'h1, 6'h14, 32'h0);
        bus(1'h1, 6'h00, 32'h2);
        // free run counts up
        bus(1'h1, 6'h18, 32'h21);
        bus(1'h0, 6'h1A, 32'h0);
        rd2 = rd;
        bus(1'h0, 6'h1A, 32'h0);
        check("free run rising", {31'h0, rd > rd2}, 32'h1);
        // pin capture
        bus(1'h1, 6'h1C, 32'h31);
        repeat (10) @(posedge i_clock);
        i_general_pin_event <= 4'h8;
        wait_bit(3, 10);
        check("capture irq", {31'h0, n < 10}, 32'h1);
        bus(1'h0, 6'h1F, 32'h0);
        rd2 = rd;
        bus(1'h0, 6'h1E, 32'h0);
        check("capture value", {31'h0, rd2 != 0 && rd2 <= rd}, 32'h1);
        i_general_pin_event <= 4'h0;
        i_clock_enable <= 1'h0;
        repeat (8) @(posedge i_clock);
        i_clock_enable <= 1'h1;
        bus(1'h1, 6'h18, 32'h0);
        bus(1'h1, 6'h1C, 32'h0);
        bus(1'h1, 6'h00, 32'hF);
        // watchdog: warn, acknowledge, warn, then system reset
        bus(1'h1, 6'h02, 32'h20);
        bus(1'h1, 6'h03, 32'h1);
        wait_bit(4, 60);
        check("watchdog first timeout", {31'h0, n >= 32 && n <= 38}, 32'h1);
        check("no reset on first", {31'h0, o_system_reset}, 32'h0);
        bus(1'h0, 6'h03, 32'h0);
        check("warned flag", rd & 32'h1, 32'h1);
        bus(1'h1, 6'h00, 32'h10);
        bus(1'h1, 6'h03, 32'h1);
        bus(1'h0, 6'h03, 32'h0);
        check("warned cleared", rd & 32'h1, 32'h0);
        wait_bit(4, 60);
        check("ack restarts count", {31'h0, n >= 26 && n <= 38 && !o_system_reset}, 32'h1);
        bus(1'h1, 6'h00, 32'h10);
        wait_bit(5, 60);
        check("second timeout resets", {31'h0, n < 60}, 32'h1);
        // a mid-run reset must clear the sticky system reset
        i_reset <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'h0;
        @(posedge i_clock);
        check("reset clears", {o_system_reset, o_irq, o_waitrequest}, 32'h1);
        tally_and_finish;
    end
endmodule

// ===== rtl/general_timers_watchdog.sv
`timescale 1ns/100ps
// How it works
// - four timers, each a 24-bit counter
// - prescale field divides by two-to-the-field
// - modes: shots, free run, pin capture
// - each timer has its own expiry interrupt
// - watchdog counts on every enabled clock, never disabled
// - first watchdog timeout raises interrupt
// - second unacknowledged timeout forces system reset
module general_timers_watchdog #(
    parameter logic [23:0] WATCHDOG_PERIOD = 24'h0F423F
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_clock_enable,
    input wire logic [timer_wdog_pkg::ADDR_WIDTH-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [timer_wdog_pkg::DATA_WIDTH-1:0] i_writedata,
    input wire logic [timer_wdog_pkg::BE_WIDTH-1:0] i_byteenable,
    output logic [timer_wdog_pkg::DATA_WIDTH-1:0] o_readdata,
    output logic o_waitrequest,
    input wire logic [timer_wdog_pkg::TIMER_NUM-1:0] i_general_pin_event,
    output logic [timer_wdog_pkg::TIMER_NUM-1:0] o_timer_irq,
    output logic o_watchdog_irq,
    output logic o_irq,
    output logic o_system_reset
);
    localparam int TN = timer_wdog_pkg::TIMER_NUM;
    localparam int CW = timer_wdog_pkg::COUNT_WIDTH;
    localparam int DW = timer_wdog_pkg::DATA_WIDTH;
    localparam int IW = timer_wdog_pkg::IRQ_WIDTH;
    localparam int PSW = timer_wdog_pkg::PRESCALE_WIDTH;

    if (TN != 4 || CW != 24) begin : g_bad_geometry
        $error("register map serves four 24-bit timers only");
    end

    // merge write data into a register under byte enables
    function automatic logic [DW-1:0] merge_bytes(
        input logic [DW-1:0] old_value,
        input logic [DW-1:0] new_value,
        input logic [timer_wdog_pkg::BE_WIDTH-1:0] lanes
    );
        logic [DW-1:0] result;
        result = old_value;
        for (int b = 0; b < timer_wdog_pkg::BE_WIDTH; b++) begin
            if (lanes[b]) begin
                result[8*b +: 8] = new_value[8*b +: 8];
            end
        end
        return result;
    endfunction

    // pin event synchroniser and rising edge detect
    logic [TN-1:0] pin_meta;
    logic [TN-1:0] pin_sync;
    logic [TN-1:0] pin_prev;
    logic [TN-1:0] pin_rise;

    // bus and register state
    logic [DW-1:0] next_readdata;
    logic next_waitrequest;
    logic [IW-1:0] irq_status;
    logic [IW-1:0] next_irq_status;
    logic [IW-1:0] irq_mask;
    logic [IW-1:0] next_irq_mask;
    logic [CW-1:0] wd_period;
    logic [CW-1:0] next_wd_period;
    logic [TN-1:0][PSW-1:0] prescale;
    logic [TN-1:0][PSW-1:0] next_prescale;
    logic [TN-1:0][1:0] mode;
    logic [TN-1:0][1:0] next_mode;
    logic [TN-1:0][CW-1:0] reload;
    logic [TN-1:0][CW-1:0] next_reload;
    logic next_system_reset;

    // decode
    logic take;
    logic wr_take;
    logic in_timer_block;
    logic [1:0] timer_sel;
    logic [1:0] slot;
    logic [DW-1:0] read_value;
    logic [DW-1:0] merged;
    logic [IW-1:0] events;
    logic [IW-1:0] clear_bits;
    logic wd_ack;
    logic [TN-1:0] timer_start;
    logic [TN-1:0] timer_stop;

    // timer and watchdog results
    logic [TN-1:0][CW-1:0] count;
    logic [TN-1:0][CW-1:0] capture;
    logic [TN-1:0] running;
    logic [TN-1:0] expired;
    logic [CW-1:0] wd_count;
    logic wd_warned;
    logic wd_timeout;
    logic wd_reset_request;

    // pins pass two flops before any logic reads them
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end else if (i_clock_enable) begin
            pin_meta <= i_general_pin_event;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_rise = pin_sync & ~pin_prev;

    // address decode; a transfer completes on the edge where waitrequest is low
    assign take = (i_read || i_write) && !o_waitrequest;
    assign wr_take = take && i_write;
    assign in_timer_block = (i_address[5:4] == timer_wdog_pkg::TIMER_BLOCK);
    assign timer_sel = i_address[3:2];
    assign slot = i_address[1:0];
    assign merged = merge_bytes(DW'(0), i_writedata, i_byteenable);
    assign wd_ack = wr_take && (i_address == timer_wdog_pkg::REG_WD_ACK);

    // control pulses to the timers from control writes
    always_comb begin
        timer_start = '0;
        timer_stop = '0;
        if (wr_take && in_timer_block && slot == timer_wdog_pkg::SLOT_CTRL && i_byteenable[0]) begin
            timer_start[timer_sel] = i_writedata[timer_wdog_pkg::CTRL_RUN_BIT];
            timer_stop[timer_sel] = !i_writedata[timer_wdog_pkg::CTRL_RUN_BIT];
        end
    end

    // four independent timer instances
    for (genvar t = 0; t < TN; t++) begin : g_timer
        gp_timer #(
            .WIDTH(CW)
        ) u_timer (
            .i_clock(i_clock),
            .i_reset(i_reset),
            .i_clock_enable(i_clock_enable),
            .i_start(timer_start[t]),
            .i_stop(timer_stop[t]),
            .i_prescale(next_prescale[t]), // a start in the same write sees the new fields
            .i_mode(next_mode[t]),
            .i_reload(reload[t]),
            .i_pin_event(pin_rise[t]),
            .o_count(count[t]),
            .o_capture(capture[t]),
            .o_running(running[t]),
            .o_expired(expired[t])
        );
    end

    // free-running watchdog
    watchdog_core #(
        .WIDTH(CW)
    ) u_watchdog (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_clock_enable(i_clock_enable),
        .i_period(wd_period),
        .i_reset_period(WATCHDOG_PERIOD),
        .i_ack(wd_ack),
        .o_count(wd_count),
        .o_warned(wd_warned),
        .o_timeout(wd_timeout),
        .o_reset_request(wd_reset_request)
    );

    // read multiplexer
    always_comb begin
        read_value = '0;
        if (in_timer_block) begin
            case (slot)
                timer_wdog_pkg::SLOT_CTRL: begin
                    read_value[timer_wdog_pkg::CTRL_RUN_BIT] = running[timer_sel];
                    read_value[timer_wdog_pkg::CTRL_PRESCALE_LSB +: PSW] = prescale[timer_sel];
                    read_value[timer_wdog_pkg::CTRL_MODE_LSB +: 2] = mode[timer_sel];
                end
                timer_wdog_pkg::SLOT_RELOAD: read_value = DW'(reload[timer_sel]);
                timer_wdog_pkg::SLOT_COUNT: read_value = DW'(count[timer_sel]);
                timer_wdog_pkg::SLOT_CAPTURE: read_value = DW'(capture[timer_sel]);
                default: read_value = '0;
            endcase
        end else begin
            case (i_address)
                timer_wdog_pkg::REG_IRQ_STATUS: read_value = DW'(irq_status);
                timer_wdog_pkg::REG_IRQ_MASK: read_value = DW'(irq_mask);
                timer_wdog_pkg::REG_WD_PERIOD: read_value = DW'(wd_period);
                timer_wdog_pkg::REG_WD_ACK: read_value = DW'(wd_warned);
                timer_wdog_pkg::REG_WD_COUNT: read_value = DW'(wd_count);
                default: read_value = '0;
            endcase
        end
    end

    // bus handshake: one wait cycle, then answer with data
    always_comb begin
        next_waitrequest = !((i_read || i_write) && o_waitrequest);
        next_readdata = o_readdata;
        if (i_read && o_waitrequest) begin
            next_readdata = read_value;
        end
    end

    // status bits: hardware set wins over a write-one clear
    assign events = {wd_timeout, expired};
    always_comb begin
        clear_bits = '0;
        if (wr_take && i_address == timer_wdog_pkg::REG_IRQ_STATUS) begin
            clear_bits = merged[IW-1:0];
        end
        next_irq_status = (irq_status & ~clear_bits) | events;
    end

    // configuration registers
    always_comb begin
        next_irq_mask = irq_mask;
        next_wd_period = wd_period;
        next_prescale = prescale;
        next_mode = mode;
        next_reload = reload;
        next_system_reset = o_system_reset || wd_reset_request;
        if (wr_take && in_timer_block) begin
            if (slot == timer_wdog_pkg::SLOT_CTRL && i_byteenable[0]) begin
                next_prescale[timer_sel] =
                    i_writedata[timer_wdog_pkg::CTRL_PRESCALE_LSB +: PSW];
                next_mode[timer_sel] = i_writedata[timer_wdog_pkg::CTRL_MODE_LSB +: 2];
            end
            if (slot == timer_wdog_pkg::SLOT_RELOAD) begin
                next_reload[timer_sel] =
                    CW'(merge_bytes(DW'(reload[timer_sel]), i_writedata, i_byteenable));
            end
        end else if (wr_take) begin
            case (i_address)
                timer_wdog_pkg::REG_IRQ_MASK: begin
                    next_irq_mask =
                        IW'(merge_bytes(DW'(irq_mask), i_writedata, i_byteenable));
                end
                timer_wdog_pkg::REG_WD_PERIOD: begin
                    next_wd_period =
                        CW'(merge_bytes(DW'(wd_period), i_writedata, i_byteenable));
                end
                default: begin
                    next_wd_period = wd_period;
                end
            endcase
        end
    end

    // register everything; reset acts even while the clock enable is low
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_readdata <= '0;
            o_waitrequest <= 1'b1;
            irq_status <= '0;
            irq_mask <= timer_wdog_pkg::MASK_RESET;
            wd_period <= WATCHDOG_PERIOD;
            prescale <= {TN{timer_wdog_pkg::PRESCALE_RESET}};
            mode <= {TN{timer_wdog_pkg::MODE_SINGLE}};
            reload <= {TN{timer_wdog_pkg::RELOAD_RESET}};
            o_timer_irq <= '0;
            o_watchdog_irq <= 1'b0;
            o_irq <= 1'b0;
            o_system_reset <= 1'b0;
        end else if (i_clock_enable) begin
            o_readdata <= next_readdata;
            o_waitrequest <= next_waitrequest;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            wd_period <= next_wd_period;
            prescale <= next_prescale;
            mode <= next_mode;
            reload <= next_reload;
            o_timer_irq <= next_irq_status[TN-1:0] & next_irq_mask[TN-1:0];
            o_watchdog_irq <= next_irq_status[timer_wdog_pkg::IRQ_WD_BIT]
                & next_irq_mask[timer_wdog_pkg::IRQ_WD_BIT];
            o_irq <= |(next_irq_status & next_irq_mask);
            o_system_reset <= next_system_reset;
        end
    end
endmodule

// ===== rtl/gp_timer.sv
`timescale 1ns/100ps
module gp_timer #(
    parameter int WIDTH = timer_wdog_pkg::COUNT_WIDTH
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_clock_enable,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [timer_wdog_pkg::PRESCALE_WIDTH-1:0] i_prescale,
    input wire logic [1:0] i_mode,
    input wire logic [WIDTH-1:0] i_reload,
    input wire logic i_pin_event,
    output logic [WIDTH-1:0] o_count,
    output logic [WIDTH-1:0] o_capture,
    output logic o_running,
    output logic o_expired
);
    localparam int PW = timer_wdog_pkg::PRESCALE_DIV_WIDTH;

    if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
        $error("gp_timer width must be 2 to 32");
    end

    logic [PW-1:0] pre_count;
    logic [PW-1:0] next_pre_count;
    logic [PW-1:0] pre_mask;
    logic tick;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] next_capture;
    logic next_running;
    logic next_expired;
    timer_wdog_pkg::timer_mode_e mode;

    assign mode = timer_wdog_pkg::timer_mode_e'(i_mode);
    // divide by two to the prescale field, 1 to 128
    assign pre_mask = ~({PW{1'b1}} << i_prescale);
    assign tick = o_running && ((pre_count & pre_mask) == pre_mask);

    // next state of prescaler, counter and capture
    always_comb begin
        next_pre_count = pre_count;
        next_count = o_count;
        next_capture = o_capture;
        next_running = o_running;
        next_expired = 1'b0;
        if (i_start) begin
            next_running = 1'b1;
            next_pre_count = '0;
            if (mode == timer_wdog_pkg::MODE_SINGLE || mode == timer_wdog_pkg::MODE_MULTI) begin
                next_count = i_reload;
            end else begin
                next_count = '0;
            end
        end else if (i_stop) begin
            next_running = 1'b0;
        end else if (o_running) begin
            next_pre_count = PW'(pre_count + 1'b1);
            if (mode == timer_wdog_pkg::MODE_CAPTURE && i_pin_event) begin
                next_capture = o_count;
                next_expired = 1'b1;
            end
            if (tick) begin
                next_pre_count = '0;
                case (mode)
                    timer_wdog_pkg::MODE_SINGLE, timer_wdog_pkg::MODE_MULTI: begin
                        if (o_count <= WIDTH'(1)) begin
                            next_expired = 1'b1;
                            next_count = i_reload;
                            next_running = (mode == timer_wdog_pkg::MODE_MULTI);
                        end else begin
                            next_count = WIDTH'(o_count - 1'b1);
                        end
                    end
                    timer_wdog_pkg::MODE_FREE: begin
                        next_count = WIDTH'(o_count + 1'b1);
                        next_expired = &o_count;
                    end
                    default: begin
                        next_count = WIDTH'(o_count + 1'b1);
                    end
                endcase
            end
        end
    end

    // register the timer state
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pre_count <= '0;
            o_count <= '0;
            o_capture <= '0;
            o_running <= 1'b0;
            o_expired <= 1'b0;
        end else if (i_clock_enable) begin
            pre_count <= next_pre_count;
            o_count <= next_count;
            o_capture <= next_capture;
            o_running <= next_running;
            o_expired <= next_expired;
        end
    end
endmodule

// ===== rtl/timer_wdog_pkg.sv
package timer_wdog_pkg;
    // bus geometry
    localparam int DATA_WIDTH = 32;
    localparam int ADDR_WIDTH = 6;
    localparam int BE_WIDTH = 4;
    // timer geometry
    localparam int TIMER_NUM = 4;
    localparam int COUNT_WIDTH = 24;
    localparam int PRESCALE_WIDTH = 3;
    localparam int PRESCALE_DIV_WIDTH = 7;
    localparam int IRQ_WIDTH = 5;
    localparam int IRQ_WD_BIT = 4;
    // register word indexes
    localparam logic [5:0] REG_IRQ_STATUS = 6'h00;
    localparam logic [5:0] REG_IRQ_MASK = 6'h01;
    localparam logic [5:0] REG_WD_PERIOD = 6'h02;
    localparam logic [5:0] REG_WD_ACK = 6'h03;
    localparam logic [5:0] REG_WD_COUNT = 6'h04;
    // timer block: index 0x10 + 4 * timer + slot
    localparam logic [1:0] TIMER_BLOCK = 2'h1;
    localparam logic [1:0] SLOT_CTRL = 2'h0;
    localparam logic [1:0] SLOT_RELOAD = 2'h1;
    localparam logic [1:0] SLOT_COUNT = 2'h2;
    localparam logic [1:0] SLOT_CAPTURE = 2'h3;
    // timer control fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_PRESCALE_LSB = 1;
    localparam int CTRL_MODE_LSB = 4;
    // reset values
    localparam logic [COUNT_WIDTH-1:0] RELOAD_RESET = 24'h000000;
    localparam logic [IRQ_WIDTH-1:0] MASK_RESET = 5'h00;
    localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 3'h0;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_MULTI = 2'b01,
        MODE_FREE = 2'b10,
        MODE_CAPTURE = 2'b11
    } timer_mode_e;

    typedef enum logic [1:0] {
        WD_COUNTING = 2'b00,
        WD_WARNED = 2'b01,
        WD_RESETTING = 2'b10
    } wd_state_e;
endpackage

// ===== rtl/watchdog_core.sv
`timescale 1ns/100ps
module watchdog_core #(
    parameter int WIDTH = timer_wdog_pkg::COUNT_WIDTH
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_clock_enable,
    input wire logic [WIDTH-1:0] i_period,
    input wire logic [WIDTH-1:0] i_reset_period,
    input wire logic i_ack,
    output logic [WIDTH-1:0] o_count,
    output logic o_warned,
    output logic o_timeout,
    output logic o_reset_request
);
    if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
        $error("watchdog_core width must be 2 to 32");
    end

    timer_wdog_pkg::wd_state_e state;
    timer_wdog_pkg::wd_state_e next_state;
    logic [WIDTH-1:0] next_count;
    logic next_timeout;
    logic next_reset_request;
    logic loaded;

    // count down, warn once, then ask for a system reset
    always_comb begin
        next_state = state;
        next_count = WIDTH'(o_count - 1'b1);
        next_timeout = 1'b0;
        next_reset_request = 1'b0;
        if (!loaded) begin
            next_count = i_reset_period;
        end else if (i_ack) begin
            next_count = i_period;
            if (state == timer_wdog_pkg::WD_WARNED) begin
                next_state = timer_wdog_pkg::WD_COUNTING;
            end
        end else if (o_count == '0) begin
            next_count = i_period;
            case (state)
                timer_wdog_pkg::WD_COUNTING: begin
                    next_timeout = 1'b1;
                    next_state = timer_wdog_pkg::WD_WARNED;
                end
                timer_wdog_pkg::WD_WARNED: begin
                    next_timeout = 1'b1;
                    next_reset_request = 1'b1;
                    next_state = timer_wdog_pkg::WD_RESETTING;
                end
                timer_wdog_pkg::WD_RESETTING: begin
                    next_reset_request = 1'b1;
                end
                default: begin
                    next_state = timer_wdog_pkg::WD_COUNTING;
                end
            endcase
        end
    end

    assign o_warned = (state != timer_wdog_pkg::WD_COUNTING);

    // always running; no path lets software stop it
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state <= timer_wdog_pkg::WD_COUNTING;
            o_count <= '0;
            loaded <= 1'b0;
            o_timeout <= 1'b0;
            o_reset_request <= 1'b0;
        end else if (i_clock_enable) begin
            state <= next_state;
            o_count <= next_count;
            loaded <= 1'b1;
            o_timeout <= next_timeout;
            o_reset_request <= next_reset_request;
        end
    end
endmodule
